// >>> rtl/flash_params.svh
// Constants for the serial flash front end.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
`define ADDR_BITS 19
`define IDX_BITS 20
`define MEM_BYTES 524288
`define OTP_BYTES 512
`define OTP_BASE 20'h80000
`define OTP_LAST 20'h001ff
`define CHIP_LAST 20'h7ffff
`define SECTOR_MASK 19'h00fff
`define HALF_MASK 19'h07fff
`define BLOCK_MASK 19'h0ffff
`define ADDR_PHASE_BITS 5'd24
`define OP_WRSR 8'h01
`define OP_PP 8'h02
`define OP_READ 8'h03
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WRITE_UNLOCK_CMD 8'h06
`define OP_FAST 8'h0b
`define OP_SE 8'h20
`define OP_OTP 8'h3a
`define OP_DOR 8'h3b
`define OP_HBE 8'h52
`define OP_CE1 8'h60
`define OP_WRAP 8'h77
`define OP_DIOR 8'hbb
`define OP_CE2 8'hc7
`define OP_BE 8'hd8
`define OP_QIOR 8'heb
`define DUMMY_FAST 5'd8
`define DUMMY_DIO 5'd4
`define DUMMY_QIO 5'd6
`define WRAP_OFF_BIT 4
`define ERASED_BYTE 8'hff
`define CLK_PERIOD_NS 4
`define T_PP_NS 300000
`define T_W_NS 1000
`endif

// >>> rtl/flash_pkg.sv
// Types shared by the serial flash front end.
package flash_pkg;
  typedef enum logic [2:0] {IDLE, CMD, ADDR, DUMMY, RD, WDATA, IGN} phase_t;
  typedef enum logic [1:0] {JOB_NONE, JOB_PROG, JOB_ERASE, JOB_WRSR} job_t;
  typedef struct packed {
    logic        cs_m, cs_s, ck_m, ck_s, ck_d;
    logic [3:0]  dq_m, dq_s;
    logic        armed;
    phase_t      phase;
    logic [7:0]  cmd, sh, obyte, wdata;
    logic [4:0]  cnt, dum;
    logic [23:0] addr;
    logic [3:0]  ocnt, dout, doe, bp;
    logic        wel, status_lock_bit, otp_lock, otp_mode, wrap_en, wip, erasing, we, clear_only;
    logic [1:0]  wrap_len;
    job_t        job;
    logic [19:0] eaddr, eend, busy, waddr;
  } st_t;
endpackage

// >>> rtl/flash_array.sv
// Byte array of the flash with its security sector appended at the top.
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_array #(
  parameter int DEPTH = `MEM_BYTES + `OTP_BYTES,
  parameter int IW    = `IDX_BITS
)
(
  // Clock
  input  wire logic          clk,
  // Read port
  input  wire logic [IW-1:0] raddr,
  output logic      [7:0]    rdata,
  // Write port
  input  wire logic          we,
  input  wire logic          clear_only,
  input  wire logic [IW-1:0] waddr,
  input  wire logic [7:0]    wdata
);
  logic [7:0] mem [0:DEPTH-1];

  // A program write can only clear bits; an erase write loads the erased value.
  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
    if (we)
      mem[waddr] <= clear_only ? (mem[waddr] & wdata) : wdata;
  end

  prog_lowers_a: assert property (@(posedge clk) we && clear_only |=>
    mem[$past(waddr)] == ($past(mem[waddr]) & $past(wdata)))
    else $error("program write set a bit");
endmodule

// >>> rtl/serial_flash_spi_front_end.sv
// Serial flash front end: pin sampling, command framing, protection and array control.
`timescale 1ns/1ps
`include "flash_params.svh"
// Operation
// - Single-line input sampled on clock rising edges.
// - Single-line output shifted on clock falling edges.
// - Clock idle low or high both work.
// - Multi-line input rises, output falls.
// - Deselected means every data line floats.
// - Only a selected device takes commands.
// - First command needs a select high-to-low.
// - Pause floats output, ignores clock and input.
// - Pause acts only outside quad operation.
// - Write-protect with the status lock bit blocks status writes.
// - Write-protect acts only outside quad operation.
// - Dual reads use lines zero and one.
// - Other commands except quad read use single in, single out.
// - Array holds 524288 bytes in pages.
// - Programming only clears bits, per page.
// - Erase by sector, block or chip.
// - Page program takes 1 to 256 bytes.
// - Internal cycles finish after deselect.
// - Quad I/O burst reads wrap at 8/16/32/64 bytes.
// - Lockable 512-byte security sector.
// - Quad read uses lines zero to three.
// - Erase refused without write unlock first.
module serial_flash_spi_front_end #(
  parameter int PP_CYC   = `T_PP_NS / `CLK_PERIOD_NS,
  parameter int WRSR_CYC = `T_W_NS / `CLK_PERIOD_NS
)
(
  // System clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Serial link pins
  input  wire logic serial_clock,
  input  wire logic chip_select_n,
  input  wire logic data_line_0_in,
  output logic      data_line_0_out,
  output logic      data_line_0_oe,
  input  wire logic data_line_1_in,
  output logic      data_line_1_out,
  output logic      data_line_1_oe,
  input  wire logic data_line_2_in,
  output logic      data_line_2_out,
  output logic      data_line_2_oe,
  input  wire logic data_line_3_in,
  output logic      data_line_3_out,
  output logic      data_line_3_oe,
  // Status
  output logic      write_in_progress
);
  flash_pkg::st_t st_reg;
  flash_pkg::st_t st_next;
  logic [7:0]     rdata;
  logic           rise;
  logic           fall;
  logic           quad;
  logic           held;
  logic           wp_n;

  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    if (op == `OP_QIOR)
      return 3'd4;
    else if (op == `OP_DIOR)
      return 3'd2;
    return 3'd1;
  endfunction

  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    if (op == `OP_QIOR)
      return 3'd4;
    else if (op == `OP_DIOR || op == `OP_DOR)
      return 3'd2;
    return 3'd1;
  endfunction

  function automatic logic [3:0] take_in(input logic [2:0] w, input logic [3:0] dq);
    if (w == 3'd4)
      return dq;
    else if (w == 3'd2)
      return {2'b00, dq[1:0]};
    return {3'b000, dq[0]};
  endfunction

  // Most significant bits leave first; a single lane drives line 1.
  function automatic logic [3:0] lane_out(input logic [2:0] w, input logic [7:0] b);
    if (w == 3'd4)
      return b[7:4];
    else if (w == 3'd2)
      return {2'b00, b[7:6]};
    return {2'b00, b[7], 1'b0};
  endfunction

  function automatic logic [3:0] oe_mask(input logic [2:0] w);
    if (w == 3'd4)
      return 4'hf;
    else if (w == 3'd2)
      return 4'h3;
    return 4'h2;
  endfunction

  function automatic logic [19:0] index_of(input logic otp, input logic [23:0] a);
    if (otp)
      return `OTP_BASE | {11'h000, a[8:0]};
    return {1'b0, a[18:0]};
  endfunction

  // Guard bits protect the top 0, 1, 2, 4 or all 8 of the 64 KB blocks.
  function automatic logic guarded(input logic [3:0] bp, input logic otp, input logic lock,
                                   input logic [23:0] a);
    logic [3:0] n;
    n = 4'h0;
    if (otp)
      return lock;
    if (bp >= 4'h4)
      n = 4'h8;
    else if (bp != 4'h0)
      n = 4'h1 << (bp - 4'h1);
    return ({1'b0, a[18:16]} + n) >= 4'h8;
  endfunction

  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap,
                                            input logic [1:0] len);
    logic [23:0] m;
    m = 24'hffffff;
    if (wrap)
      m = (24'h000008 << len) - 24'h000001;
    return (a & ~m) | ((a + 24'h000001) & m);
  endfunction

  assign rise = st_reg.ck_s & ~st_reg.ck_d;
  assign fall = ~st_reg.ck_s & st_reg.ck_d;
  assign quad = st_reg.cmd == `OP_QIOR && st_reg.phase != flash_pkg::IDLE && st_reg.phase != flash_pkg::CMD;
  assign held = ~st_reg.cs_s & ~quad & ~st_reg.dq_s[3];
  assign wp_n = quad | st_reg.dq_s[2];

  always_comb
  begin
    logic [2:0]  w;
    logic [7:0]  b;
    logic [23:0] a;
    logic [18:0] m;
    w = 3'd1;
    b = 8'h00;
    a = 24'h000000;
    m = 19'h00000;
    st_next = st_reg;
    st_next.cs_m = chip_select_n;
    st_next.cs_s = st_reg.cs_m;
    st_next.ck_m = serial_clock;
    st_next.ck_s = st_reg.ck_m;
    st_next.ck_d = st_reg.ck_s;
    st_next.dq_m = {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in};
    st_next.dq_s = st_reg.dq_m;
    st_next.we = 1'b0;
    if (st_reg.cs_s)
      st_next.armed = 1'b1;
    // Internal cycles run on regardless of the select pin.
    if (st_reg.erasing)
    begin
      st_next.we = 1'b1;
      st_next.clear_only = 1'b0;
      st_next.waddr = st_reg.eaddr;
      st_next.wdata = `ERASED_BYTE;
      st_next.eaddr = st_reg.eaddr + 20'h00001;
      if (st_reg.eaddr == st_reg.eend)
      begin
        st_next.erasing = 1'b0;
        st_next.wip = 1'b0;
      end
    end
    else if (st_reg.busy != 20'h00000)
    begin
      st_next.busy = st_reg.busy - 20'h00001;
      if (st_reg.busy == 20'h00001)
        st_next.wip = 1'b0;
    end
    if (st_reg.phase == flash_pkg::IDLE)
    begin
      if (!st_reg.cs_s && st_reg.armed)
      begin
        st_next.phase = flash_pkg::CMD;
        st_next.armed = 1'b0;
        st_next.cmd = 8'h00;
        st_next.sh = 8'h00;
        st_next.cnt = 5'd0;
        st_next.ocnt = 4'h0;
        st_next.job = flash_pkg::JOB_NONE;
      end
    end
    else if (st_reg.cs_s)
    begin
      st_next.phase = flash_pkg::IDLE;
      // Only whole bytes commit a modifying command.
      if ((st_reg.phase == flash_pkg::WDATA || st_reg.phase == flash_pkg::IGN) && st_reg.cnt[2:0] == 3'd0)
      begin
        case (st_reg.job)
          flash_pkg::JOB_ERASE:
          begin
            st_next.erasing = 1'b1;
            st_next.wip = 1'b1;
            st_next.wel = 1'b0;
          end
          flash_pkg::JOB_PROG:
          begin
            st_next.busy = 20'(PP_CYC);
            st_next.wip = 1'b1;
            st_next.wel = 1'b0;
          end
          flash_pkg::JOB_WRSR:
          begin
            st_next.busy = 20'(WRSR_CYC);
            st_next.wip = 1'b1;
            st_next.wel = 1'b0;
            if (st_reg.otp_mode)
              st_next.otp_lock = st_reg.otp_lock | st_reg.sh[7];
            else
            begin
              st_next.bp = st_reg.sh[5:2];
              st_next.status_lock_bit = st_reg.sh[7];
            end
          end
          default:
          begin
          end
        endcase
      end
    end
    else if (!held && rise)
    begin
      case (st_reg.phase)
        flash_pkg::CMD:
        begin
          b = {st_reg.sh[6:0], st_reg.dq_s[0]};
          st_next.sh = b;
          st_next.cnt = st_reg.cnt + 5'd1;
          if (st_reg.cnt == 5'd7)
          begin
            st_next.cmd = b;
            st_next.cnt = 5'd0;
            st_next.phase = flash_pkg::IGN;
            if (st_reg.wip && b != `OP_RDSR)
              st_next.phase = flash_pkg::IGN;
            else if (b == `OP_WRITE_UNLOCK_CMD)
              st_next.wel = 1'b1;
            else if (b == `OP_WRDI)
            begin
              st_next.wel = 1'b0;
              st_next.otp_mode = 1'b0;
            end
            else if (b == `OP_OTP)
              st_next.otp_mode = 1'b1;
            else if (b == `OP_RDSR)
              st_next.phase = flash_pkg::RD;
            else if (b == `OP_WRSR || b == `OP_WRAP)
              st_next.phase = flash_pkg::WDATA;
            else if (b == `OP_CE1 || b == `OP_CE2)
            begin
              if (st_reg.wel && st_reg.bp == 4'h0 && !st_reg.otp_mode)
              begin
                st_next.job = flash_pkg::JOB_ERASE;
                st_next.eaddr = 20'h00000;
                st_next.eend = `CHIP_LAST;
              end
            end
            else if (b == `OP_PP || b == `OP_SE || b == `OP_HBE || b == `OP_BE || b == `OP_READ ||
                     b == `OP_FAST || b == `OP_DOR || b == `OP_DIOR || b == `OP_QIOR)
              st_next.phase = flash_pkg::ADDR;
          end
        end
        flash_pkg::ADDR:
        begin
          w = addr_lanes(st_reg.cmd);
          a = (st_reg.addr << w) | {20'h00000, take_in(w, st_reg.dq_s)};
          st_next.addr = a;
          st_next.cnt = st_reg.cnt + 5'(w);
          if (st_reg.cnt + 5'(w) == `ADDR_PHASE_BITS)
          begin
            st_next.cnt = 5'd0;
            st_next.phase = flash_pkg::IGN;
            if (st_reg.cmd == `OP_SE)
              m = `SECTOR_MASK;
            else if (st_reg.cmd == `OP_HBE)
              m = `HALF_MASK;
            else
              m = `BLOCK_MASK;
            if (st_reg.cmd == `OP_PP)
            begin
              if (st_reg.wel && !guarded(st_reg.bp, st_reg.otp_mode, st_reg.otp_lock, a))
                st_next.phase = flash_pkg::WDATA;
            end
            else if (st_reg.cmd == `OP_SE || st_reg.cmd == `OP_HBE || st_reg.cmd == `OP_BE)
            begin
              if (st_reg.wel && !guarded(st_reg.bp, st_reg.otp_mode, st_reg.otp_lock, a))
              begin
                st_next.job = flash_pkg::JOB_ERASE;
                st_next.eaddr = st_reg.otp_mode ? `OTP_BASE : {1'b0, a[18:0] & ~m};
                st_next.eend = st_reg.otp_mode ? (`OTP_BASE | `OTP_LAST) : {1'b0, a[18:0] | m};
              end
            end
            else if (st_reg.cmd == `OP_READ)
              st_next.phase = flash_pkg::RD;
            else
            begin
              st_next.phase = flash_pkg::DUMMY;
              st_next.dum = (st_reg.cmd == `OP_QIOR) ? `DUMMY_QIO :
                            (st_reg.cmd == `OP_DIOR) ? `DUMMY_DIO : `DUMMY_FAST;
            end
          end
        end
        flash_pkg::DUMMY:
        begin
          st_next.cnt = st_reg.cnt + 5'd1;
          if (st_reg.cnt + 5'd1 == st_reg.dum)
          begin
            st_next.cnt = 5'd0;
            st_next.phase = flash_pkg::RD;
          end
        end
        flash_pkg::WDATA:
        begin
          b = {st_reg.sh[6:0], st_reg.dq_s[0]};
          st_next.sh = b;
          st_next.cnt = {2'b00, st_reg.cnt[2:0] + 3'd1};
          if (st_reg.cnt[2:0] == 3'd7)
          begin
            if (st_reg.cmd == `OP_PP)
            begin
              st_next.we = 1'b1;
              st_next.clear_only = 1'b1;
              st_next.waddr = index_of(st_reg.otp_mode, st_reg.addr);
              st_next.wdata = b;
              st_next.addr[7:0] = st_reg.addr[7:0] + 8'h01;
              st_next.job = flash_pkg::JOB_PROG;
            end
            else if (st_reg.cmd == `OP_WRSR)
            begin
              st_next.phase = flash_pkg::IGN;
              if (st_reg.wel && !(st_reg.status_lock_bit && !wp_n))
                st_next.job = flash_pkg::JOB_WRSR;
            end
            else
            begin
              st_next.phase = flash_pkg::IGN;
              st_next.wrap_en = ~b[`WRAP_OFF_BIT];
              st_next.wrap_len = b[6:5];
            end
          end
        end
        flash_pkg::IGN:
          st_next.cnt = {2'b00, st_reg.cnt[2:0] + 3'd1};
        default:
        begin
        end
      endcase
    end
    else if (!held && fall && st_reg.phase == flash_pkg::RD)
    begin
      w = data_lanes(st_reg.cmd);
      b = st_reg.obyte;
      if (st_reg.ocnt == 4'h0)
      begin
        if (st_reg.cmd == `OP_RDSR)
          b = {st_reg.otp_mode ? st_reg.otp_lock : st_reg.status_lock_bit, 1'b0, st_reg.bp, st_reg.wel, st_reg.wip};
        else
        begin
          b = rdata;
          st_next.addr = next_addr(st_reg.addr, st_reg.wrap_en && st_reg.cmd == `OP_QIOR, st_reg.wrap_len);
        end
      end
      st_next.dout = lane_out(w, b);
      st_next.obyte = b << w;
      st_next.ocnt = ((st_reg.ocnt == 4'h0) ? 4'h8 : st_reg.ocnt) - 4'(w);
    end
    // Drivers stay off outside the read phase, while paused and once deselected.
    st_next.doe = 4'h0;
    if (st_next.phase == flash_pkg::RD && !held && !st_reg.cs_s)
      st_next.doe = oe_mask(data_lanes(st_next.cmd));
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  flash_array u_array (
    .clk   (clk),
    .raddr (index_of(st_reg.otp_mode, st_reg.addr)),
    .rdata (rdata),
    .we    (st_reg.we),
    .clear_only (st_reg.clear_only),
    .waddr (st_reg.waddr),
    .wdata (st_reg.wdata)
  );

  assign data_line_0_out = st_reg.dout[0];
  assign data_line_1_out = st_reg.dout[1];
  assign data_line_2_out = st_reg.dout[2];
  assign data_line_3_out = st_reg.dout[3];
  assign data_line_0_oe = st_reg.doe[0];
  assign data_line_1_oe = st_reg.doe[1];
  assign data_line_2_oe = st_reg.doe[2];
  assign data_line_3_oe = st_reg.doe[3];
  assign write_in_progress = st_reg.wip;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  frame_needs_arm_a: assert property (st_reg.phase == flash_pkg::CMD &&
    $past(st_reg.phase) == flash_pkg::IDLE |-> $past(st_reg.armed) && !$past(st_reg.cs_s))
    else $error("frame opened without a select transition");
  desel_float_a: assert property (st_reg.cs_s |=> st_reg.doe == 4'h0)
    else $error("driver on while deselected");
  hold_float_a: assert property (held |=> st_reg.doe == 4'h0)
    else $error("driver on while paused");
  quad_lanes_a: assert property (st_reg.phase == flash_pkg::RD && st_reg.cmd == `OP_QIOR &&
    !st_reg.cs_s |=> st_reg.doe == 4'hf)
    else $error("quad read lost a lane");
  dual_lanes_a: assert property (st_reg.phase == flash_pkg::RD && !held && !st_reg.cs_s &&
    (st_reg.cmd == `OP_DOR || st_reg.cmd == `OP_DIOR) |=> st_reg.doe == 4'h3)
    else $error("dual read lanes wrong");
  single_lanes_a: assert property (st_reg.phase == flash_pkg::RD && !held && !st_reg.cs_s &&
    st_reg.cmd == `OP_READ |=> st_reg.doe == 4'h2)
    else $error("single read lanes wrong");
  out_on_fall_a: assert property (st_reg.dout != $past(st_reg.dout) |-> $past(fall))
    else $error("output moved off a falling edge");
  in_on_rise_a: assert property ($past(st_reg.phase) != flash_pkg::IDLE &&
    st_reg.sh != $past(st_reg.sh) |-> $past(rise))
    else $error("input taken off a rising edge");
  erase_unlock_a: assert property ($rose(st_reg.erasing) |-> $past(st_reg.wel))
    else $error("erase started without unlock");
  hw_lock_a: assert property (st_reg.job == flash_pkg::JOB_WRSR &&
    $past(st_reg.job) != flash_pkg::JOB_WRSR |-> !$past(st_reg.status_lock_bit && !wp_n))
    else $error("status write accepted under hardware lock");
  busy_runs_a: assert property (st_reg.wip && st_reg.busy > 20'h00003 |=>
    st_reg.wip ##1 st_reg.wip)
    else $error("internal cycle cut short");

  quad_read_c: cover property (st_reg.phase == flash_pkg::RD && st_reg.cmd == `OP_QIOR);
  dual_read_c: cover property (st_reg.phase == flash_pkg::RD && st_reg.cmd == `OP_DIOR);
  erase_c: cover property ($rose(st_reg.erasing));
  program_c: cover property ($rose(st_reg.job == flash_pkg::JOB_PROG));
  hold_c: cover property (held && st_reg.phase == flash_pkg::RD);
endmodule

// >>> tb/spi_host_model.sv
// SPI host model that drives the link clock, the select and the data lanes.
`timescale 1ns/1ps
module spi_host_model
(
  // Link pins
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      hout,
  output logic [3:0]      hoe,
  input  wire logic [3:0] line
);
  logic idle_hi = 1'b0;

  // The bench calls this at time zero, so every link pin is driven from one process only.
  task automatic init();
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hout = 4'h0;
    hoe  = 4'h0;
  end
  endtask

  task automatic open_frame(input logic m3);
  begin
    idle_hi = m3;
    sclk = m3;
    #62.5 cs_n = 1'b0;
    #62.5;
  end
  endtask

  // Lanes 0 and 1 are released before select rises so the device never sees a clash.
  task automatic close_frame();
  begin
    hoe[1:0] = 2'h0;
    #62.5 sclk = idle_hi;
    #62.5 cs_n = 1'b1;
    #125;
  end
  endtask

  // Each clock puts data on the lanes while low and samples the lanes at the rising edge.
  task automatic shift(input logic [31:0] v, input int n, input int ln, input logic drv, output logic [31:0] r);
    int i;
    int k;
  begin
    r = 32'h0;
    for (i = 0; i < n; i++)
    begin
      sclk = 1'b0;
      for (k = 0; k < ln; k++)
      begin
        hout[k] = v[(n-1-i)*ln+k];
        hoe[k] = drv;
      end
      #62.5 sclk = 1'b1;
      for (k = ln - 1; k >= 0; k--)
        r = {r[30:0], (ln == 1) ? line[1] : line[k]};
      #62.5;
    end
  end
  endtask
endmodule

// >>> tb/serial_flash_spi_front_end_tb_top.sv
// Self-checking testbench for the serial flash front end.
`timescale 1ns/1ps
module serial_flash_spi_front_end_tb_top;
  logic        clk;
  logic        reset_n;
  logic        sclk;
  logic        cs_n;
  logic        tgl = 1'b0;
  logic        seen_oe = 1'b0;
  logic        wip;
  logic [3:0]  hout;
  logic [3:0]  hoe;
  logic [3:0]  dout;
  logic [3:0]  doe;
  logic [3:0]  line;
  logic [31:0] r;
  int          fail_count = 0;
  int          n_tests = 0;
  int          i;
  logic [7:0]  ops [5] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'heb};

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    tgl <= ~tgl;
    if ((|doe) === 1'b1)
      seen_oe <= 1'b1;
  end

  // Released data lines show a changing pattern; write-protect and pause have pull-ups.
  assign line[0] = doe[0] ? dout[0] : hoe[0] ? hout[0] : tgl;
  assign line[1] = doe[1] ? dout[1] : hoe[1] ? hout[1] : ~tgl;
  assign line[2] = doe[2] ? dout[2] : hoe[2] ? hout[2] : 1'b1;
  assign line[3] = doe[3] ? dout[3] : hoe[3] ? hout[3] : 1'b1;

  serial_flash_spi_front_end #(.PP_CYC(20), .WRSR_CYC(4)) DUT
  (
    .clk(clk),
    .reset_n(reset_n),
    .serial_clock(sclk),
    .chip_select_n(cs_n),
    .data_line_0_in(line[0]),
    .data_line_0_out(dout[0]),
    .data_line_0_oe(doe[0]),
    .data_line_1_in(line[1]),
    .data_line_1_out(dout[1]),
    .data_line_1_oe(doe[1]),
    .data_line_2_in(line[2]),
    .data_line_2_out(dout[2]),
    .data_line_2_oe(doe[2]),
    .data_line_3_in(line[3]),
    .data_line_3_out(dout[3]),
    .data_line_3_oe(doe[3]),
    .write_in_progress(wip)
  );

  spi_host_model host
  (
    .sclk(sclk),
    .cs_n(cs_n),
    .hout(hout),
    .hoe(hoe),
    .line(line)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task automatic close_out();
  begin
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  task automatic send(input logic [7:0] op, input logic na, input logic [23:0] a, input int nd, input logic [31:0] d);
  begin
    host.open_frame(1'b0);
    host.shift({24'h0, op}, 8, 1, 1'b1, r);
    if (na)
      host.shift({8'h0, a}, 24, 1, 1'b1, r);
    if (nd > 0)
      host.shift(d, nd * 8, 1, 1'b1, r);
    host.close_frame();
  end
  endtask

  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic m3, input int nb, output logic [31:0] q);
    int al;
    int ln;
    int dm;
  begin
    al = (op == 8'hbb) ? 2 : (op == 8'heb) ? 4 : 1;
    ln = (op == 8'h3b) ? 2 : al;
    dm = (op == 8'h0b || op == 8'h3b) ? 8 : (op == 8'hbb) ? 4 : (op == 8'heb) ? 6 : 0;
    host.open_frame(m3);
    host.shift({24'h0, op}, 8, 1, 1'b1, q);
    if (op != 8'h05)
      host.shift({8'h0, a}, 24 / al, al, 1'b1, q);
    if (dm > 0)
      host.shift(32'h0, dm, al, 1'b0, q);
    host.shift(32'h0, nb * 8 / ln, ln, ln == 1, q);
    host.close_frame();
  end
  endtask

  // A busy flag that never drops ends the run.
  task automatic wait_idle();
  begin
    for (i = 0; i < 5000 && wip !== 1'b0; i++)
      @(negedge clk);
    check("idle", {31'h0, wip}, 32'h0);
    if (wip !== 1'b0)
      close_out();
  end
  endtask

  initial
  begin
    host.init();
    reset_n = 1'b0;
    @(negedge clk);
    host.cs_n = 1'b0;
    repeat (9) @(negedge clk);
    check("reset oe", {28'h0, doe}, 32'h0);
    check("reset wip", {31'h0, wip}, 32'h0);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    host.shift(32'h0500, 16, 1, 1'b1, r);
    check("unarmed oe", {31'h0, seen_oe}, 32'h0);
    host.close_frame();
    check("deselect oe", {28'h0, doe}, 32'h0);
    $display("test select done");
    send(8'h20, 1'b1, 24'h0, 0, 32'h0);
    check("erase locked", {31'h0, wip}, 32'h0);
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    rd(8'h05, 24'h0, 1'b0, 1, r);
    check("status wel", r, 32'h02);
    send(8'h20, 1'b1, 24'h0, 0, 32'h0);
    check("erase busy", {31'h0, wip}, 32'h1);
    wait_idle();
    $display("test erase done");
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h02, 1'b1, 24'h000ffe, 4, 32'ha53c960f);
    wait_idle();
    rd(8'h03, 24'h000ffe, 1'b0, 2, r);
    check("page head", r, 32'ha53c);
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h02, 1'b1, 24'h000ffe, 1, 32'h0f);
    wait_idle();
    for (i = 0; i < 5; i++)
    begin
      rd(ops[i], 24'h000f00, i[0], 2, r);
      check("read modes", r, 32'h960f);
    end
    send(8'h77, 1'b0, 24'h0, 1, 32'h00);
    rd(8'heb, 24'h000ffe, 1'b0, 4, r);
    check("wrap and clear", r, 32'h053cffff);
    $display("test program done");
    host.open_frame(1'b0);
    host.shift(32'h03000f00, 32, 1, 1'b1, r);
    host.shift(32'h0, 8, 1, 1'b1, r);
    check("pause first", r, 32'h96);
    host.hout[3] = 1'b0;
    host.hoe[3] = 1'b1;
    #250;
    host.shift(32'h0, 4, 1, 1'b1, r);
    check("pause float", {28'h0, doe}, 32'h0);
    host.hoe[3] = 1'b0;
    #250;
    host.shift(32'h0, 8, 1, 1'b1, r);
    check("pause resume", r, 32'h0f);
    host.close_frame();
    check("read deselect oe", {28'h0, doe}, 32'h0);
    $display("test pause done");
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h01, 1'b0, 24'h0, 1, 32'h84);
    wait_idle();
    host.hout[2] = 1'b0;
    host.hoe[2] = 1'b1;
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h01, 1'b0, 24'h0, 1, 32'h00);
    wait_idle();
    rd(8'h05, 24'h0, 1'b0, 1, r);
    check("status held", r & 32'hfc, 32'h84);
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h20, 1'b1, 24'h07f000, 0, 32'h0);
    check("guarded erase", {31'h0, wip}, 32'h0);
    host.hoe[2] = 1'b0;
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h01, 1'b0, 24'h0, 1, 32'h00);
    wait_idle();
    rd(8'h05, 24'h0, 1'b0, 1, r);
    check("status open", r, 32'h00);
    $display("test protect done");
    send(8'h3a, 1'b0, 24'h0, 0, 32'h0);
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h20, 1'b1, 24'h0, 0, 32'h0);
    check("secure erase", {31'h0, wip}, 32'h1);
    wait_idle();
    send(8'h06, 1'b0, 24'h0, 0, 32'h0);
    send(8'h02, 1'b1, 24'h000f00, 1, 32'h5a);
    wait_idle();
    rd(8'h03, 24'h000f00, 1'b0, 1, r);
    check("secure byte", r, 32'h5a);
    send(8'h04, 1'b0, 24'h0, 0, 32'h0);
    rd(8'h03, 24'h000f00, 1'b0, 1, r);
    check("main byte", r, 32'h96);
    $display("test security done");
    close_out();
  end
endmodule
